// ==== acl_cfg.svh ====
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH
// Behaviour
// - Priority mode picks none, greater, smaller, always
// - Remark enable replaces PCP with remark value
// - Map mode 01 ORs rule and lookup maps
// - Map mode 10 ANDs rule and lookup maps
// - Mode 11 replaces map, 00 passes through
// - Forward map bit n means port n+1
// - Timeout algorithm loads and decrements 11-bit counter
// - Timeout expiry raises the port interrupt
// - Tick unit bit selects microseconds or milliseconds
// - Counting algorithm increments per matched packet
// - Terminal count raises interrupt, then count restarts
// - Table holds sixteen entries per port
// - Count mode ties matching and action fields
// - Count mode reads action as count settings
// - Only count mode events raise interrupts
// - Separate ACL status and mask per port
// - Global per-port status and mask level
// - Count value is the low eleven action bits

`define ACL_ENTRIES 16
`define ACL_MAX_PORTS 8
`define ACL_CLK_NS 10
`define ACL_US_NS 1000
`define ACL_MS_US 1000
`define ACL_US_CYC (`ACL_US_NS / `ACL_CLK_NS)

`define ACL_REG_SEL 8'h00
`define ACL_REG_ACTION 8'h04
`define ACL_REG_COUNT 8'h08
`define ACL_REG_PSTAT 8'h0c
`define ACL_REG_PMASK 8'h10
`define ACL_REG_GSTAT 8'h14
`define ACL_REG_GMASK 8'h18

`define ACL_SEL_ENTRY 3:0
`define ACL_SEL_PORT 6:4
`define ACL_ACT_BITS 24:0
`define ACL_COUNT_BITS 10:0

`define ACL_PM_NONE 2'h0
`define ACL_PM_GREATER 2'h1
`define ACL_PM_SMALLER 2'h2
`define ACL_PM_ALWAYS 2'h3
`define ACL_MM_PASS 2'h0
`define ACL_MM_OR 2'h1
`define ACL_MM_AND 2'h2
`define ACL_MM_REPLACE 2'h3
`define ACL_MODE_L2 2'h1
`define ACL_ENB_COUNT 2'h0
`define ACL_CA_TIMEOUT 1'h0
`define ACL_CA_COUNT 1'h1
`endif

// ==== acl_lkp_model.sv ====
`timescale 1ns/1ps
module acl_lkp_model (
  // Clock.
  input wire logic ref_clk,
  // Lookup result towards the action stage.
  output acl_pkg::acl_req_t req_o
);
  initial req_o = '0;

  // Once a request is taken every field is inverted, so a stale value can
  // never pass for a fresh one.
  task automatic send(input logic [2:0] port, input logic hit,
                      input logic [3:0] entry, input logic [2:0] qos,
                      input logic [2:0] pcp, input logic [7:0] map);
    @(posedge ref_clk);
    req_o <= {1'b1, port, hit, entry, qos, pcp, map};
    @(posedge ref_clk);
    req_o <= {1'b0, ~port, ~hit, ~entry, ~qos, ~pcp, ~map};
  endtask : send
endmodule : acl_lkp_model

// ==== acl_pkg.sv ====
package acl_pkg;
  typedef struct packed {
    logic [1:0] rule_mode;
    logic [1:0] compare_enable_code;
    logic [7:0] fwd_map;
    logic counter_algorithm;
    logic tick_unit_select;
    logic [1:0] map_mode;
    logic [2:0] remark_priority_value;
    logic remark_enable;
    logic [2:0] prio;
    logic [1:0] priority_select_mode;
  } acl_entry_t;

  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic hit;
    logic [3:0] entry;
    logic [2:0] qos_prio;
    logic [2:0] pcp;
    logic [7:0] map;
  } acl_req_t;

  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic [2:0] prio;
    logic [2:0] pcp;
    logic [7:0] map;
  } acl_res_t;
endpackage : acl_pkg

// ==== acl_unit.sv ====
`timescale 1ns/1ps
`include "acl_cfg.svh"
module acl_unit #(
  parameter int NPORT = 7
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Lookup result in, forwarding decision out.
  input acl_pkg::acl_req_t req_i,
  output acl_pkg::acl_res_t res_o,
  // Interrupt.
  output logic irq_o
);
  localparam int ALL = NPORT * `ACL_ENTRIES;

  if (NPORT < 1 || NPORT > `ACL_MAX_PORTS) begin : g_chk
    $error("NPORT must lie between 1 and the maximum port count.");
  end

  function automatic int flat(input logic [2:0] p, input logic [3:0] e);
    return int'(p) * `ACL_ENTRIES + int'(e);
  endfunction : flat

  function automatic logic is_count(input acl_pkg::acl_entry_t e);
    return e.rule_mode == `ACL_MODE_L2 &&
           e.compare_enable_code == `ACL_ENB_COUNT;
  endfunction : is_count

  // Tick generator.
  logic [6:0] us_cnt_q, us_cnt_d;
  logic [9:0] ms_cnt_q, ms_cnt_d;
  logic us_tick_q, us_tick_d, ms_tick_q, ms_tick_d;

  always_comb begin
    us_cnt_d = us_cnt_q + 7'h01;
    ms_cnt_d = ms_cnt_q;
    us_tick_d = 1'b0;
    ms_tick_d = 1'b0;
    if (us_cnt_q == 7'(`ACL_US_CYC - 1)) begin
      us_cnt_d = 7'h00;
      us_tick_d = 1'b1;
      ms_cnt_d = ms_cnt_q + 10'h001;
      if (ms_cnt_q == 10'(`ACL_MS_US - 1)) begin
        ms_cnt_d = 10'h000;
        ms_tick_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      us_cnt_q <= 7'h00;
      ms_cnt_q <= 10'h000;
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
    end else begin
      us_cnt_q <= us_cnt_d;
      ms_cnt_q <= ms_cnt_d;
      us_tick_q <= us_tick_d;
      ms_tick_q <= ms_tick_d;
    end
  end

  // Rule table, counters and registers.
  acl_pkg::acl_entry_t tbl_q [ALL];
  acl_pkg::acl_entry_t tbl_d [ALL];
  logic [10:0] cnt_q [ALL];
  logic [10:0] cnt_d [ALL];
  logic [ALL-1:0] run_q, run_d;
  logic [6:0] sel_q, sel_d;
  logic [NPORT-1:0] pstat_q, pstat_d, pmask_q, pmask_d;
  logic [NPORT-1:0] gmask_q, gmask_d, gstat, ev;
  logic [31:0] rdata_d;
  logic irq_d;
  int sel_i, req_i_idx;
  logic req_ok;

  assign sel_i = flat(sel_q[`ACL_SEL_PORT], sel_q[`ACL_SEL_ENTRY]);
  assign req_i_idx = flat(req_i.port, req_i.entry);
  assign req_ok = req_i.valid && req_i.hit && int'(req_i.port) < NPORT;
  // The global level sees only what the port level lets through.
  assign gstat = pstat_q & ~pmask_q;

  always_comb begin
    logic tick;
    logic hitp;
    logic load;
    tick = 1'b0;
    hitp = 1'b0;
    load = 1'b0;
    tbl_d = tbl_q;
    cnt_d = cnt_q;
    run_d = run_q;
    ev = '0;
    for (int i = 0; i < ALL; i++) begin
      load = reg_wr && reg_addr == `ACL_REG_ACTION && sel_i == i;
      hitp = req_ok && req_i_idx == i;
      tick = tbl_q[i].tick_unit_select ? ms_tick_q : us_tick_q;
      if (load) begin
        tbl_d[i] = acl_pkg::acl_entry_t'(reg_wdata[`ACL_ACT_BITS]);
      end
      if (!is_count(tbl_q[i]) || load) begin
        // A rewritten entry restarts its counter from a clean state.
        cnt_d[i] = 11'h000;
        run_d[i] = 1'b0;
      end else if (tbl_q[i].counter_algorithm == `ACL_CA_TIMEOUT) begin
        if (hitp) begin
          cnt_d[i] = tbl_q[i][`ACL_COUNT_BITS];
          run_d[i] = 1'b1;
        end else if (run_q[i] && tick) begin
          if (cnt_q[i] <= 11'h001) begin
            cnt_d[i] = 11'h000;
            run_d[i] = 1'b0;
            ev[i / `ACL_ENTRIES] = 1'b1;
          end else begin
            cnt_d[i] = cnt_q[i] - 11'h001;
          end
        end
      end else if (hitp) begin
        // Counting ignores the tick unit entirely.
        if (cnt_q[i] + 11'h001 >= tbl_q[i][`ACL_COUNT_BITS]) begin
          cnt_d[i] = 11'h000;
          ev[i / `ACL_ENTRIES] = 1'b1;
        end else begin
          cnt_d[i] = cnt_q[i] + 11'h001;
        end
      end
    end
  end

  always_comb begin
    sel_d = sel_q;
    pmask_d = pmask_q;
    gmask_d = gmask_q;
    pstat_d = pstat_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        `ACL_REG_SEL: sel_d = reg_wdata[6:0];
        `ACL_REG_PSTAT: pstat_d = pstat_q & ~reg_wdata[NPORT-1:0];
        `ACL_REG_PMASK: pmask_d = reg_wdata[NPORT-1:0];
        `ACL_REG_GMASK: gmask_d = reg_wdata[NPORT-1:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    pstat_d = pstat_d | ev;
    if (reg_rd) begin
      unique case (reg_addr)
        `ACL_REG_SEL: rdata_d = {25'h0, sel_q};
        `ACL_REG_ACTION:
          if (sel_i < ALL) rdata_d = {7'h00, tbl_q[sel_i]};
        `ACL_REG_COUNT:
          if (sel_i < ALL) rdata_d = {21'h0, cnt_q[sel_i]};
        `ACL_REG_PSTAT: rdata_d[NPORT-1:0] = pstat_q;
        `ACL_REG_PMASK: rdata_d[NPORT-1:0] = pmask_q;
        `ACL_REG_GSTAT: rdata_d[NPORT-1:0] = gstat;
        `ACL_REG_GMASK: rdata_d[NPORT-1:0] = gmask_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(gstat & ~gmask_q);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ALL; i++) begin
        tbl_q[i] <= '0;
        cnt_q[i] <= 11'h000;
      end
      run_q <= '0;
      sel_q <= 7'h00;
      pstat_q <= '0;
      pmask_q <= '1;
      gmask_q <= '1;
      reg_rdata <= 32'h0000_0000;
      irq_o <= 1'b0;
    end else begin
      tbl_q <= tbl_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      sel_q <= sel_d;
      pstat_q <= pstat_d;
      pmask_q <= pmask_d;
      gmask_q <= gmask_d;
      reg_rdata <= rdata_d;
      irq_o <= irq_d;
    end
  end

  // Action stage.
  acl_pkg::acl_res_t res_d;
  acl_pkg::acl_entry_t act;
  acl_pkg::acl_entry_t act_q;
  logic filt, filt_q;

  assign act = req_ok ? tbl_q[req_i_idx] : '0;
  // Count-mode entries never alter the packet; they only feed counters.
  assign filt = req_ok && !is_count(act);

  always_comb begin
    res_d.valid = req_i.valid;
    res_d.port = req_i.port;
    res_d.prio = req_i.qos_prio;
    res_d.pcp = req_i.pcp;
    res_d.map = req_i.map;
    if (filt) begin
      unique case (act.priority_select_mode)
        `ACL_PM_NONE: res_d.prio = req_i.qos_prio;
        `ACL_PM_GREATER:
          if (act.prio > req_i.qos_prio) res_d.prio = act.prio;
        `ACL_PM_SMALLER:
          if (act.prio < req_i.qos_prio) res_d.prio = act.prio;
        `ACL_PM_ALWAYS: res_d.prio = act.prio;
      endcase
      if (act.remark_enable) begin
        res_d.pcp = act.remark_priority_value;
      end
      // Bit n of both maps stands for port n+1, so they combine bitwise.
      unique case (act.map_mode)
        `ACL_MM_PASS: res_d.map = req_i.map;
        `ACL_MM_OR: res_d.map = req_i.map | act.fwd_map;
        `ACL_MM_AND: res_d.map = req_i.map & act.fwd_map;
        `ACL_MM_REPLACE: res_d.map = act.fwd_map;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      res_o <= '0;
      act_q <= '0;
      filt_q <= 1'b0;
    end else begin
      res_o <= res_d;
      act_q <= act;
      filt_q <= filt;
    end
  end

  a_prio_always: assert property (@(posedge ref_clk) disable iff (rst)
    res_o.valid && filt_q &&
    act_q.priority_select_mode == `ACL_PM_ALWAYS |-> res_o.prio == act_q.prio)
    else $error("Priority was not forced.");

  a_prio_greater: assert property (@(posedge ref_clk) disable iff (rst)
    filt_q && act_q.priority_select_mode == `ACL_PM_GREATER |->
    res_o.prio == ((act_q.prio > $past(req_i.qos_prio)) ? act_q.prio :
                   $past(req_i.qos_prio)))
    else $error("Greater-than priority choice is wrong.");

  a_remark_pcp: assert property (@(posedge ref_clk) disable iff (rst)
    filt_q |-> res_o.pcp == (act_q.remark_enable ?
               act_q.remark_priority_value : $past(req_i.pcp)))
    else $error("PCP remark is wrong.");

  a_map_or: assert property (@(posedge ref_clk) disable iff (rst)
    filt_q && act_q.map_mode == `ACL_MM_OR |->
    res_o.map == ($past(req_i.map) | act_q.fwd_map))
    else $error("OR map is wrong.");

  a_map_and: assert property (@(posedge ref_clk) disable iff (rst)
    filt_q && act_q.map_mode == `ACL_MM_AND |->
    res_o.map == ($past(req_i.map) & act_q.fwd_map))
    else $error("AND map is wrong.");

  a_map_pass: assert property (@(posedge ref_clk) disable iff (rst)
    res_o.valid && (!filt_q || act_q.map_mode == `ACL_MM_PASS) |->
    res_o.map == $past(req_i.map))
    else $error("Lookup map was altered.");

  a_status_latch: assert property (@(posedge ref_clk) disable iff (rst)
    |ev |=> (pstat_q & $past(ev)) == $past(ev))
    else $error("Event did not latch its status bit.");

  a_irq_output: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 irq_o == $past(|(pstat_q & ~pmask_q & ~gmask_q)))
    else $error("Interrupt output does not follow masked status.");

  a_us_tick: assert property (@(posedge ref_clk) disable iff (rst)
    us_tick_q |=> !us_tick_q [*8])
    else $error("Microsecond tick came too soon.");

endmodule : acl_unit

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "acl_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
  end end
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  acl_pkg::acl_req_t req;
  acl_pkg::acl_res_t res_o;
  logic irq_o;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [2:0] q;
  logic [2:0] ep;
  logic [7:0] mt [4] = '{8'h3c, 8'h7e, 8'h18, 8'h5a};

  acl_unit #(.NPORT(7)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_i(req), .res_o(res_o),
    .irq_o(irq_o));
  acl_lkp_model lkp_u (.ref_clk(ref_clk), .req_o(req));

  always #5 ref_clk = ~ref_clk;

  // The whole run needs about seven hundred cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d, checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd

  function automatic logic [31:0] mk(input logic [1:0] rm,
    input logic [7:0] fwd, input logic ca, input logic [1:0] mm,
    input logic [2:0] rv, input logic re, input logic [2:0] pr,
    input logic [1:0] pm);
    acl_pkg::acl_entry_t e;
    e = {rm, 2'h0, fwd, ca, 1'b0, mm, rv, re, pr, pm};
    return {7'h00, e};
  endfunction : mk

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`ACL_REG_PSTAT, 32'h0);
    rd(8'h40, 32'h0);
    wr(`ACL_REG_SEL, 32'h0f);
    wr(`ACL_REG_ACTION, mk(2'h2, 8'ha5, 1'b0, 2'h1, 3'h3, 1'b1, 3'h5, 2'h2));
    rd(`ACL_REG_ACTION, mk(2'h2, 8'ha5, 1'b0, 2'h1, 3'h3, 1'b1, 3'h5, 2'h2));
    wr(`ACL_REG_SEL, 32'h70);
    rd(`ACL_REG_ACTION, 32'h0);
    // Every priority and map mode, with remarking toggled alongside.
    wr(`ACL_REG_SEL, 32'h21);
    for (int i = 0; i < 4; i++) begin
      wr(`ACL_REG_ACTION, mk(2'h2, 8'h5a, 1'b0, i[1:0], 3'h5, i[0], 3'h4,
        i[1:0]));
      for (int j = 0; j < 2; j++) begin
        q = (j == 1) ? 3'h6 : 3'h2;
        lkp_u.send(3'h2, 1'b1, 4'h1, q, 3'h2, 8'h3c);
        #1;
        case (i)
          0: ep = q;
          1: ep = (3'h4 > q) ? 3'h4 : q;
          2: ep = (3'h4 < q) ? 3'h4 : q;
          default: ep = 3'h4;
        endcase
        `CHK({res_o.valid, res_o.port}, 4'ha)
        `CHK(res_o.prio, ep)
        `CHK(res_o.pcp, i[0] ? 3'h5 : 3'h2)
        `CHK(res_o.map, mt[i])
      end
    end
    lkp_u.send(3'h2, 1'b0, 4'h1, 3'h2, 3'h2, 8'h3c);
    #1;
    `CHK(res_o.map, 8'h3c)
    rd(`ACL_REG_PSTAT, 32'h0);
    // Packet counting on port 3 with a terminal count of 3.
    wr(`ACL_REG_SEL, 32'h32);
    wr(`ACL_REG_ACTION, mk(2'h1, 8'h00, 1'b1, 2'h0, 3'h0, 1'b0, 3'h0, 2'h3));
    for (int k = 1; k <= 3; k++) begin
      lkp_u.send(3'h3, 1'b1, 4'h2, 3'h1, 3'h1, 8'h81);
      #1;
      `CHK(res_o.map, 8'h81)
      rd(`ACL_REG_COUNT, 32'(k % 3));
      if (k < 3) rd(`ACL_REG_PSTAT, 32'h0);
    end
    rd(`ACL_REG_PSTAT, 32'h08);
    `CHK(irq_o, 1'b0)
    wr(`ACL_REG_PMASK, ~32'h08);
    rd(`ACL_REG_GSTAT, 32'h08);
    `CHK(irq_o, 1'b0)
    wr(`ACL_REG_GMASK, ~32'h08);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(irq_o, 1'b1)
    wr(`ACL_REG_PSTAT, 32'h08);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(irq_o, 1'b0)
    // Timeout on port 4 of two microsecond ticks.
    wr(`ACL_REG_SEL, 32'h43);
    wr(`ACL_REG_ACTION, mk(2'h1, 8'h00, 1'b0, 2'h0, 3'h0, 1'b0, 3'h0, 2'h2));
    lkp_u.send(3'h4, 1'b1, 4'h3, 3'h1, 3'h1, 8'h81);
    repeat (`ACL_US_CYC - 10) @(posedge ref_clk);
    rd(`ACL_REG_PSTAT, 32'h0);
    repeat (2 * `ACL_US_CYC) @(posedge ref_clk);
    rd(`ACL_REG_PSTAT, 32'h10);
    // Millisecond unit on port 5: no expiry within a few microseconds.
    wr(`ACL_REG_PSTAT, 32'h10);
    wr(`ACL_REG_SEL, 32'h54);
    wr(`ACL_REG_ACTION,
      mk(2'h1, 8'h00, 1'b0, 2'h0, 3'h0, 1'b0, 3'h0, 2'h2) | 32'h800);
    lkp_u.send(3'h5, 1'b1, 4'h4, 3'h1, 3'h1, 8'h81);
    repeat (3 * `ACL_US_CYC) @(posedge ref_clk);
    rd(`ACL_REG_PSTAT, 32'h0);
    rd(`ACL_REG_COUNT, 32'h2);
    stop_test();
  end
endmodule : tb_top
